// >>> logic/pci_config_space_target.sv
// PCI configuration space registers, seen from PCI config cycles and local side.
// Assumes PCI-side config requests are held stable across a PCLK rising edge.
module pci_config_space_target
	import cfg_space_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        HOLD_STRAP,
	input  wire logic        PCLK,
	input  wire logic        CFG_STB,
	input  wire cfg_req_t    CFG_REQ,
	output logic             CFG_ACK,
	output logic             CFG_RETRY,
	output logic [31:0]      CFG_RDATA,
	input  wire logic        LOC_SEL,
	input  wire logic        LOC_WE,
	input  wire logic [7:0]  LOC_ADDR,
	input  wire logic [3:0]  LOC_BE,
	input  wire logic [31:0] LOC_WDATA,
	output logic             LOC_ACK,
	output logic [31:0]      LOC_RDATA,
	input  wire logic        TGT_VALID,
	input  wire logic [31:0] TGT_ADDR,
	output logic             TGT_HIT,
	output logic [1:0]       TGT_REGION,
	output logic [31:0]      TGT_LADDR,
	output logic             TGT_CACHED,
	input  wire logic        INIT_REQ,
	output logic             INIT_GO,
	input  wire err_ev_t     ERR_EV,
	output logic             SERR_N_O,
	output logic             SERR_N_OE_N,
	output logic             PERR_N_O,
	output logic             PERR_N_OE_N,
	output logic             PAR_IRQ,
	output logic             MASTER_EN,
	output logic             MEM_EN
);

	// ==========================================
	// Helpers
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [31:0] size_mask(input int w, input logic [31:0] wc);
		logic [5:0] m;
		m = wc[w*WIN_B_SH + WF_MASK +: 6];
		if (w == 2)
			return ~32'h0 << REG_WIN_LSB;
		return {4'hf, ~m, {XL_LSB{1'b0}}};
	endfunction

	// ==========================================
	// Synchronisers: PCLK, strobe, strap
	logic [2:0] s0_q, s1_q, s2_q;
	cfg_req_t   rq1_q, rq2_q, rq3_q;
	logic       pclk_lvl_q;
	logic       pclk_rise, stb_ok, pci_take;

	always_ff @(posedge MCLK) begin
		s0_q  <= {HOLD_STRAP, CFG_STB, PCLK};
		s1_q  <= s0_q;
		s2_q  <= s1_q;
		rq1_q <= CFG_REQ;
		rq2_q <= rq1_q;
		rq3_q <= rq2_q;
	end

	always_ff @(posedge MCLK) begin
		if (RST)
			pclk_lvl_q <= 1'b0;
		else if (s1_q[0] == s2_q[0])
			pclk_lvl_q <= s2_q[0];
	end

	assign pclk_rise = s1_q[0] & s2_q[0] & ~pclk_lvl_q;
	assign stb_ok    = s1_q[1] & s2_q[1];
	assign pci_take  = pclk_rise & stb_ok;

	// ==========================================
	// Config cycle hold
	logic [1:0] strap_cnt_q;
	logic       hold_q;
	logic       pend_q;
	cfg_req_t   pend_req_q;
	logic       pci_serve;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			strap_cnt_q <= 2'h0;
			hold_q      <= 1'b1;
		end else if (strap_cnt_q != 2'h3) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'h2)
				hold_q <= s1_q[2] & s2_q[2];
		end else if (LOC_SEL && LOC_WE && LOC_ADDR[7:2] == IDX_CTRL && LOC_BE[0]) begin
			hold_q <= LOC_WDATA[CTRL_HOLD];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST)
			CFG_RETRY <= 1'b0;
		else
			CFG_RETRY <= pci_take & hold_q;
	end

	// Local side wins the register port; a PCI access waits one cycle at most per local access
	assign pci_serve = pend_q & ~LOC_SEL;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			pend_q     <= 1'b0;
			pend_req_q <= '0;
		end else if (pci_take && !hold_q && !pend_q) begin
			pend_q     <= 1'b1;
			pend_req_q <= rq3_q;
		end else if (pci_serve) begin
			pend_q <= 1'b0;
		end
	end

	// ==========================================
	// Common access port
	logic        acc_en, acc_we, acc_loc;
	logic [5:0]  acc_idx;
	logic [3:0]  acc_be;
	logic [31:0] acc_wd;

	// local side sees low 256 bytes
	assign acc_loc = LOC_SEL;
	assign acc_en  = LOC_SEL | pci_serve;
	assign acc_we  = acc_en & (LOC_SEL ? LOC_WE : pend_req_q.we);
	assign acc_idx = LOC_SEL ? LOC_ADDR[7:2] : pend_req_q.idx;
	assign acc_be  = LOC_SEL ? LOC_BE : pend_req_q.be;
	assign acc_wd  = LOC_SEL ? LOC_WDATA : pend_req_q.wdata;

	// ==========================================
	// Command register
	logic cmd_serr_q, cmd_parr_q;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			cmd_serr_q <= 1'b0;
			cmd_parr_q <= 1'b0;
			MASTER_EN  <= 1'b0;
			MEM_EN     <= 1'b0;
		end else if (acc_we && acc_idx == IDX_CMD) begin
			if (acc_be[1])
				cmd_serr_q <= acc_wd[CMD_SERR];
			if (acc_be[0]) begin
				cmd_parr_q <= acc_wd[CMD_PARR];
				MASTER_EN  <= acc_wd[CMD_MAST];
				MEM_EN     <= acc_wd[CMD_MEM];
			end
		end
	end

	// ==========================================
	// Status register
	logic [4:0] st_q, st_set, st_clr;
	logic       pe_any;

	assign pe_any = ERR_EV.par_rd | ERR_EV.par_twr;
	assign st_set = {pe_any, ERR_EV.addr_par & cmd_serr_q, ERR_EV.mabort, ERR_EV.tabort,
		(ERR_EV.par_rd | ERR_EV.perr_rcvd) & cmd_parr_q};
	assign st_clr = (acc_we && acc_idx == IDX_CMD && acc_be[3]) ?
		{acc_wd[ST_PE], acc_wd[ST_SERR], acc_wd[ST_MABORT], acc_wd[ST_TABORT],
		acc_wd[ST_INIT_PE]} : 5'h00;

	always_ff @(posedge MCLK) begin
		if (RST)
			st_q <= 5'h00;
		else
			st_q <= (st_q & ~st_clr) | st_set;
	end

	// ==========================================
	// Base registers and window config
	logic [31:0] bar_q [3];
	logic [31:0] wincfg_q;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			for (int i = 0; i < 3; i++)
				bar_q[i] <= 32'h0;
		end else if (acc_we) begin
			for (int i = 0; i < 3; i++) begin
				if (acc_idx == IDX_BAR0 + 6'(i)) begin
					bar_q[i][31:BAR_LSB] <= 28'(be_merge(bar_q[i], acc_wd, acc_be) >> BAR_LSB);
					if (acc_loc && acc_be[0] && i < 2)
						bar_q[i][BAR_PF] <= acc_wd[BAR_PF];
				end
			end
		end
	end

	// mask reset gives 16 Mbyte windows
	always_ff @(posedge MCLK) begin
		if (RST)
			wincfg_q <= WINCFG_RST;
		else if (acc_we && acc_loc && acc_idx == IDX_WINCFG)
			wincfg_q <= be_merge(wincfg_q, acc_wd, acc_be);
	end

	function automatic logic [31:0] rd_word(input logic [5:0] idx, input logic loc);
		logic [31:0] r;
		r = 32'h0;
		case (idx)
			IDX_ID:    r = ID_WORD;
			IDX_CMD: begin
				r[CMD_SERR] = cmd_serr_q;
				r[CMD_PARR] = cmd_parr_q;
				r[CMD_MAST] = MASTER_EN;
				r[CMD_MEM]  = MEM_EN;
				r[ST_DEVSEL +: 2] = DEVSEL_MED;
				{r[ST_PE], r[ST_SERR], r[ST_MABORT], r[ST_TABORT], r[ST_INIT_PE]} = st_q;
			end
			IDX_CLASS: r = CLASS_WORD;
			IDX_WINCFG: r = loc ? wincfg_q : 32'h0;
			IDX_CTRL:   r = loc ? {31'h0, hold_q} : 32'h0;
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (idx == IDX_BAR0 + 6'(i))
						r = (bar_q[i] & size_mask(i, wincfg_q)) |
							{28'h0, bar_q[i][BAR_PF], 3'h0};
				end
			end
		endcase
		return r;
	endfunction

	always_ff @(posedge MCLK) begin
		if (RST) begin
			LOC_ACK   <= 1'b0;
			LOC_RDATA <= 32'h0;
			CFG_ACK   <= 1'b0;
			CFG_RDATA <= 32'h0;
		end else begin
			LOC_ACK <= LOC_SEL;
			CFG_ACK <= pci_serve;
			if (LOC_SEL)
				LOC_RDATA <= rd_word(LOC_ADDR[7:2], 1'b1);
			if (pci_serve)
				CFG_RDATA <= rd_word(pend_req_q.idx, 1'b0);
		end
	end

	// ==========================================
	// Target decode and translation
	logic [2:0]  hit;
	logic [31:0] xl_a, xl_b;

	function automatic logic [31:0] xlate(input int w, input logic [31:0] a,
		input logic [31:0] wc);
		logic [5:0] m, t;
		logic [31:0] r;
		m = wc[w*WIN_B_SH + WF_MASK +: 6];
		t = wc[w*WIN_B_SH + WF_TRANS +: 6];
		r = {4'h0, (a[27:XL_LSB] & ~m) | t, a[XL_LSB-1:0]};
		r[LOC_IO] = wc[w*WIN_B_SH + WF_IO];
		return r;
	endfunction

	generate
		for (genvar g = 0; g < 3; g++) begin : g_hit
			assign hit[g] = ((TGT_ADDR ^ bar_q[g]) & size_mask(g, wincfg_q)) == 32'h0;
		end
	endgenerate

	assign xl_a = xlate(0, TGT_ADDR, wincfg_q);
	assign xl_b = xlate(1, TGT_ADDR, wincfg_q);

	always_ff @(posedge MCLK) begin
		if (RST) begin
			TGT_HIT    <= 1'b0;
			TGT_REGION <= 2'h0;
			TGT_LADDR  <= 32'h0;
			TGT_CACHED <= 1'b0;
		end else begin
			TGT_HIT <= TGT_VALID & MEM_EN & (|hit);
			if (hit[0]) begin
				TGT_REGION <= 2'h0;
				TGT_LADDR  <= xl_a;
				TGT_CACHED <= wincfg_q[WF_CACHED];
			end else if (hit[1]) begin
				TGT_REGION <= 2'h1;
				TGT_LADDR  <= xl_b;
				TGT_CACHED <= wincfg_q[WIN_B_SH + WF_CACHED];
			end else begin
				TGT_REGION <= 2'h2;
				TGT_LADDR  <= TGT_ADDR & ~size_mask(2, wincfg_q);
				TGT_CACHED <= 1'b0;
			end
		end
	end

	// ==========================================
	// Initiator gate and error pins
	always_ff @(posedge MCLK) begin
		if (RST) begin
			INIT_GO     <= 1'b0;
			SERR_N_O    <= 1'b0;
			SERR_N_OE_N <= 1'b1;
			PERR_N_O    <= 1'b0;
			PERR_N_OE_N <= 1'b1;
			PAR_IRQ     <= 1'b0;
		end else begin
			INIT_GO     <= INIT_REQ & MASTER_EN;
			SERR_N_OE_N <= ~(ERR_EV.addr_par & cmd_serr_q);
			PERR_N_OE_N <= ~(pe_any & cmd_parr_q);
			PAR_IRQ     <= pe_any & cmd_parr_q;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	property p_retry;
		pci_take && hold_q |=> CFG_RETRY && !CFG_ACK;
	endproperty
	a_retry: assert property (p_retry) else $error("held config not retried");

	property p_serr;
		ERR_EV.addr_par |=> (SERR_N_OE_N == !$past(cmd_serr_q)) && (st_q[3] || !$past(cmd_serr_q));
	endproperty
	a_serr: assert property (p_serr) else $error("serr or status 30 wrong");

	property p_perr;
		pe_any && !cmd_parr_q |=> PERR_N_OE_N && !PAR_IRQ;
	endproperty
	a_perr: assert property (p_perr) else $error("parity response while off");

	property p_init;
		!MASTER_EN |=> !INIT_GO;
	endproperty
	a_init: assert property (p_init) else $error("initiator start while off");

	property p_mem;
		!MEM_EN |=> !TGT_HIT;
	endproperty
	a_mem: assert property (p_mem) else $error("target claim while off");

	property p_pe;
		pe_any |=> st_q[4] [*2] or (st_q[4] ##1 $past(st_clr[4]));
	endproperty
	a_pe: assert property (p_pe) else $error("status 31 not held");

	property p_const;
		CFG_ACK |-> CFG_RDATA[27:25] == 3'h1 || $past(pend_req_q.idx) != IDX_CMD;
	endproperty
	a_const: assert property (p_const) else $error("devsel field wrong");

	property p_w1c;
		st_q[2] && st_clr[2] && !ERR_EV.mabort |=> !st_q[2];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");

	property p_xl;
		TGT_HIT && TGT_REGION != 2'h2 |-> TGT_LADDR[31:29] == 3'h0;
	endproperty
	a_xl: assert property (p_xl) else $error("local address top not cleared");

endmodule

// >>> logic/cfg_space_pkg.sv
// Constants, field layouts and carrier types for the PCI configuration space block.
// Assumes a single 200 MHz clock; PCI-side signals arrive asynchronously.
package cfg_space_pkg;

	// ==========================================
	// Register word indices (byte offset = index * 4)
	localparam logic [5:0] IDX_ID     = 6'h00;
	localparam logic [5:0] IDX_CMD    = 6'h01;
	localparam logic [5:0] IDX_CLASS  = 6'h02;
	localparam logic [5:0] IDX_BAR0   = 6'h04;
	localparam logic [5:0] IDX_BAR2   = 6'h06;
	localparam logic [5:0] IDX_WINCFG = 6'h10;
	localparam logic [5:0] IDX_CTRL   = 6'h11;

	// Arbitrary identity and class words, not assigned to any maker
	localparam logic [31:0] ID_WORD    = 32'h0001_0001;
	localparam logic [31:0] CLASS_WORD = 32'h0580_0000;

	// ==========================================
	// Command and status bit positions
	localparam int CMD_MEM  = 1;
	localparam int CMD_MAST = 2;
	localparam int CMD_PARR = 6;
	localparam int CMD_SERR = 8;
	localparam int ST_INIT_PE = 24;
	localparam int ST_DEVSEL  = 25;
	localparam int ST_TABORT  = 28;
	localparam int ST_MABORT  = 29;
	localparam int ST_SERR    = 30;
	localparam int ST_PE      = 31;
	localparam logic [1:0] DEVSEL_MED = 2'h1;
	localparam int BAR_PF   = 3;
	localparam int BAR_LSB  = 4;

	// ==========================================
	// Window translation layout, per window
	localparam int WF_MASK   = 0;
	localparam int WF_TRANS  = 6;
	localparam int WF_CACHED = 12;
	localparam int WF_IO     = 13;
	localparam int WIN_B_SH  = 14;
	localparam int XL_LSB    = 22;
	localparam int LOC_IO    = 28;
	localparam logic [31:0] WINCFG_RST = 32'h0000_c003;
	localparam int REG_WIN_LSB = 16;
	localparam int CTRL_HOLD = 0;

	typedef struct packed {
		logic        we;
		logic [5:0]  idx;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic par_rd;
		logic par_twr;
		logic addr_par;
		logic mabort;
		logic tabort;
		logic perr_rcvd;
	} err_ev_t;

endpackage

// >>> verif/pci_cfg_host.sv
// Behavioural PCI configuration host driving the config request pins.
// Assumes the bench calls access() for one request at a time.
module pci_cfg_host
	import cfg_space_pkg::*;
(
	input  wire logic        MCLK,
	output logic             PCLK,
	output logic             CFG_STB,
	output cfg_req_t         CFG_REQ,
	input  wire logic        CFG_ACK,
	input  wire logic        CFG_RETRY,
	input  wire logic [31:0] CFG_RDATA
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		PCLK = 1'b0;
		CFG_STB = 1'b0;
		CFG_REQ = '0;
	end

	// ==========================================
	// One request per PCLK rise
	// Clock idles low between frames, as a stopped link would
	task automatic access(input cfg_req_t r, output logic [31:0] rd, output logic rty);
		int n;
		n = 0;
		CFG_REQ = r;
		CFG_STB = 1'b1;
		#24 PCLK = 1'b1;
		while (n < 40 && CFG_ACK !== 1'b1 && CFG_RETRY !== 1'b1) begin
			@(posedge MCLK);
			n++;
			if (n == 5)
				PCLK = 1'b0;
		end
		// No answer at all is flagged as unknown for the bench
		rty = (n < 40) ? CFG_RETRY : 1'bx;
		rd = CFG_RDATA;
		PCLK = 1'b0;
		CFG_STB = 1'b0;
		// Released data inverted so stale values never pass
		CFG_REQ.wdata = ~r.wdata;
		#24;
	endtask
endmodule

// >>> verif/pci_config_space_target_tb.sv
// Self-checking bench for the configuration space block.
// Assumes the host model in pci_cfg_host.sv drives the PCI config pins.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", nm, e, g); end end

module pci_config_space_target_tb
	import cfg_space_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        MCLK, RST, HOLD_STRAP, PCLK, CFG_STB, CFG_ACK, CFG_RETRY, rty;
	logic        LOC_SEL, LOC_WE, LOC_ACK, TGT_VALID, TGT_HIT, TGT_CACHED, INIT_REQ, INIT_GO;
	logic        SERR_N_O, SERR_N_OE_N, PERR_N_O, PERR_N_OE_N, PAR_IRQ, MASTER_EN, MEM_EN;
	logic [1:0]  TGT_REGION, io, ch;
	logic [3:0]  LOC_BE;
	logic [5:0]  ev, msk [2], trn [2];
	logic [7:0]  LOC_ADDR, st;
	logic [31:0] CFG_RDATA, LOC_WDATA, LOC_RDATA, TGT_ADDR, TGT_LADDR, rd, ta, c, seed;
	logic [31:0] ba [3], szs [3];
	cfg_req_t    CFG_REQ;
	err_ev_t     ERR_EV;
	int          err_count, n_compared, cyc;

	pci_config_space_target u_pci_config_space_target (.MCLK, .RST, .HOLD_STRAP, .PCLK,
		.CFG_STB, .CFG_REQ, .CFG_ACK, .CFG_RETRY, .CFG_RDATA, .LOC_SEL, .LOC_WE, .LOC_ADDR,
		.LOC_BE, .LOC_WDATA, .LOC_ACK, .LOC_RDATA, .TGT_VALID, .TGT_ADDR, .TGT_HIT, .TGT_REGION,
		.TGT_LADDR, .TGT_CACHED, .INIT_REQ, .INIT_GO, .ERR_EV, .SERR_N_O, .SERR_N_OE_N,
		.PERR_N_O, .PERR_N_OE_N, .PAR_IRQ, .MASTER_EN, .MEM_EN);
	pci_cfg_host u_pci_cfg_host (.MCLK, .PCLK, .CFG_STB, .CFG_REQ, .CFG_ACK, .CFG_RETRY,
		.CFG_RDATA);

	// ==========================================
	// Clock, timeout, helpers
	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end

	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			wrap_up();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic loc(input logic we, input logic [5:0] ix, input logic [3:0] be,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge MCLK);
		LOC_SEL <= 1'b1;
		LOC_WE <= we;
		LOC_ADDR <= {ix, 2'b00};
		LOC_BE <= be;
		LOC_WDATA <= wd;
		@(posedge MCLK);
		LOC_SEL <= 1'b0;
		LOC_WDATA <= ~wd;
		do begin
			@(posedge MCLK);
			n++;
		end while (LOC_ACK !== 1'b1 && n < 4);
		if (LOC_ACK !== 1'b1)
			err_count++;
		rd = LOC_RDATA;
	endtask

	task automatic cfg(input logic we, input logic [5:0] ix, input logic [31:0] wd);
		u_pci_cfg_host.access(cfg_req_t'{we, ix, 4'hf, wd}, rd, rty);
		if (rty === 1'bx)
			err_count++;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		seed = 32'h0001_6ffc;
		{RST, HOLD_STRAP, LOC_SEL, LOC_WE, TGT_VALID, INIT_REQ} = 6'h30;
		{LOC_ADDR, LOC_BE, LOC_WDATA, TGT_ADDR} = '0;
		ERR_EV = '0;
		{err_count, n_compared, cyc} = '0;
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		repeat (6) @(posedge MCLK);
		loc(0, IDX_CMD, 4'hf, 32'h0);
		`CHK("cmd_status_rst", 32'h0200_0000, rd)
		cfg(0, IDX_ID, 32'h0);
		`CHK("held_retry", 1'b1, rty)
		// Masks are contiguous so sizes stay powers of two; window a keeps the default
		msk[0] = 6'h03;
		msk[1] = 6'h3f >> (xs() % 7);
		trn[0] = 6'(xs());
		trn[1] = 6'(xs());
		{io, ch} = 4'(xs());
		loc(1, IDX_WINCFG, 4'hf, {4'h0, io[1], ch[1], trn[1], msk[1], io[0], ch[0], trn[0], msk[0]});
		for (int k = 0; k < 3; k++)
			loc(1, 6'(IDX_BAR0 + k), 4'hf, (k < 2) ? 32'h8 : 32'h0);
		loc(1, IDX_CTRL, 4'hf, 32'h0);
		for (int k = 0; k < 3; k++) begin
			szs[k] = (k == 2) ? 32'hffff_0000 : {4'hf, ~msk[k], 22'h0};
			cfg(1, 6'(IDX_BAR0 + k), 32'hffff_ffff);
			cfg(0, 6'(IDX_BAR0 + k), 32'h0);
			`CHK("bar_size", szs[k] | ((k < 2) ? 32'h8 : 32'h0), rd)
			c = xs();
			// Distinct top nibble keeps the three windows apart
			c[31:28] = 4'(k);
			cfg(1, 6'(IDX_BAR0 + k), c);
			cfg(0, 6'(IDX_BAR0 + k), 32'h0);
			ba[k] = c & szs[k];
			`CHK("bar_base", ba[k] | ((k < 2) ? 32'h8 : 32'h0), rd)
		end
		cfg(1, IDX_CMD, 32'h0000_ffff);
		cfg(0, IDX_CMD, 32'h0);
		`CHK("cmd_pci", 32'h0200_0146, rd)
		for (int p = 0; p < 2; p++) begin
			c = p ? 32'h0 : 32'h0146;
			loc(1, IDX_CMD, 4'h3, c);
			`CHK("enables", {c[2], c[1]}, {MASTER_EN, MEM_EN})
			for (int k = 0; k < 3; k++) begin
				ta = ba[k] | (xs() & ~szs[k]);
				@(posedge MCLK);
				TGT_ADDR <= ta;
				TGT_VALID <= 1'b1;
				INIT_REQ <= ta[0];
				@(posedge MCLK);
				TGT_VALID <= 1'b0;
				@(posedge MCLK);
				`CHK("init_go", ta[0] & c[2], INIT_GO)
				`CHK("hit", c[1], TGT_HIT)
				if (c[1])
					`CHK("region", 2'(k), TGT_REGION)
				if (c[1] && k < 2) begin
					`CHK("laddr", {3'h0, io[k], (ta[27:22] & ~msk[k]) | trn[k], ta[21:0]}, TGT_LADDR)
					`CHK("cached", ch[k], TGT_CACHED)
				end
			end
			for (int e = 0; e < 6; e++) begin
				ev = 6'h20 >> e;
				@(posedge MCLK);
				ERR_EV <= err_ev_t'(ev);
				@(posedge MCLK);
				ERR_EV <= '0;
				@(posedge MCLK);
				`CHK("serr_oe_n", ~(ev[3] & c[8]), SERR_N_OE_N)
				`CHK("perr_oe_n", ~((ev[5] | ev[4]) & c[6]), PERR_N_OE_N)
				`CHK("par_irq", (ev[5] | ev[4]) & c[6], PAR_IRQ)
				`CHK("err_pins_o", 2'h0, {SERR_N_O, PERR_N_O})
				st = {ev[5] | ev[4], ev[3] & c[8], ev[2], ev[1], 3'b001, c[6] & (ev[5] | ev[0])};
				loc(1, IDX_CMD, 4'h8, 32'h0);
				loc(0, IDX_CMD, 4'hf, 32'h0);
				`CHK("status_set", st, rd[31:24])
				loc(1, IDX_CMD, 4'h8, 32'hff00_0000);
				loc(0, IDX_CMD, 4'hf, 32'h0);
				`CHK("status_clr", 8'h02, rd[31:24])
			end
		end
		wrap_up();
	end
endmodule
